// >>> osec_ctrl.sv
module osec_ctrl
#(
   parameter bit AUTO_SECONDARY_OSCILLATOR   = 1'b1,
   parameter bit HAS_96M_PLL = 1'b1
)
(
   input  wire logic          clk_sys_in,
   input  wire logic          rst_in,
   input  wire logic [7:0]    s_axi_awaddr_in,
   input  wire logic          s_axi_awvalid_in,
   output logic               s_axi_awready_out,
   input  wire logic [31:0]   s_axi_wdata_in,
   input  wire logic [3:0]    s_axi_wstrb_in,
   input  wire logic          s_axi_wvalid_in,
   output logic               s_axi_wready_out,
   output logic [1:0]         s_axi_bresp_out,
   output logic               s_axi_bvalid_out,
   input  wire logic          s_axi_bready_in,
   input  wire logic [7:0]    s_axi_araddr_in,
   input  wire logic          s_axi_arvalid_in,
   output logic               s_axi_arready_out,
   output logic [31:0]        s_axi_rdata_out,
   output logic [1:0]         s_axi_rresp_out,
   output logic               s_axi_rvalid_out,
   input  wire logic          s_axi_rready_in,
   output logic               s_axi_rvalid_dummy_out,
   input  wire logic          sleep_in,
   input  wire logic          powerup_timer_expired_in,
   input  wire logic          clock_fail_in,
   input  wire logic          periph_needs_secondary_oscillator_in,
   input  wire logic [2:0]    initial_source_config_in,
   output osec_pkg::osec_en_type osc_en_out,
   output logic [2:0]         current_clock_source_out,
   output logic [2:0]         fast_rc_divider_select_out
);
   localparam int LOCK_CW = osec_pkg::LOCK_CW;
   osec_pkg::osec_state_type s_r;
   osec_pkg::osec_state_type s_nxt;
   logic                     wr_fire;
   logic                     sw_start;

   function automatic logic uses_pll(input logic [2:0] src);
      uses_pll = (src == osec_pkg::SRC_FRC_PLL) || (src == osec_pkg::SRC_PRI_PLL);
   endfunction : uses_pll

   function automatic logic is_frc(input logic [2:0] src);
      is_frc = (src == osec_pkg::SRC_FRC_DIV) || (src == osec_pkg::SRC_FRC_PLL)
               || (src == osec_pkg::SRC_FRC);
   endfunction : is_frc

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   function automatic logic [31:0] ctrl_word(input osec_pkg::osec_state_type st);
      logic [31:0] w;
      w = 32'h0;
      w[osec_pkg::CUR_SRC_LSB +: 3]  = st.cur_src;
      w[osec_pkg::NEXT_SRC_LSB +: 3] = st.next_src;
      w[osec_pkg::LOCK_BIT]          = st.lock;
      w[osec_pkg::CF_BIT]            = st.cf;
      w[osec_pkg::KEEP_ON_BIT]       = st.keep_on;
      w[osec_pkg::SWITCH_BIT]        = st.sw_go;
      ctrl_word = w;
   endfunction : ctrl_word

   always_comb
   begin
      logic [31:0] wd;
      logic [31:0] rd;
      logic [2:0]  target;
      logic        digital;
      logic        to_sec;
      logic        to_frc;
      logic        to_low_power_internal_rc;
      wd       = 32'h0;
      rd       = 32'h0;
      s_nxt    = s_r;
      wr_fire  = 1'b0;
      sw_start = 1'b0;
      target   = (s_r.sw == osec_pkg::SW_WAIT) ? s_r.next_src : s_r.cur_src;
      digital  = s_r.cfg[1:0] == osec_pkg::SMODE_DIGITAL;
      to_sec   = (s_r.cur_src == osec_pkg::SRC_SEC)
                 || ((s_r.sw == osec_pkg::SW_WAIT) && (s_r.next_src == osec_pkg::SRC_SEC));
      to_frc   = is_frc(s_r.cur_src) || ((s_r.sw == osec_pkg::SW_WAIT) && is_frc(s_r.next_src));
      to_low_power_internal_rc  = (s_r.cur_src == osec_pkg::SRC_LOW_POWER_INTERNAL_RC)
                 || ((s_r.sw == osec_pkg::SW_WAIT) && (s_r.next_src == osec_pkg::SRC_LOW_POWER_INTERNAL_RC));

      // Write address and data are taken independently
      if (s_r.awready && s_axi_awvalid_in)
      begin
         s_nxt.aw_got  = 1'b1;
         s_nxt.awaddr  = s_axi_awaddr_in;
         s_nxt.awready = 1'b0;
      end
      if (s_r.wready && s_axi_wvalid_in)
      begin
         s_nxt.w_got  = 1'b1;
         s_nxt.wdata  = s_axi_wdata_in;
         s_nxt.wstrb  = s_axi_wstrb_in;
         s_nxt.wready = 1'b0;
      end
      if (s_r.bvalid && s_axi_bready_in)
      begin
         s_nxt.bvalid  = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready  = 1'b1;
      end

      // Lock counter runs while the target source (next source while a switch waits, else the current one) uses the PLL
      if (uses_pll(target))
      begin
         if (!s_r.lock)
         begin
            if (s_r.lock_cnt == LOCK_CW'(osec_pkg::LOCK_CYC - 1))
            begin
               s_nxt.lock = 1'b1;
            end
            else
            begin
               s_nxt.lock_cnt = s_r.lock_cnt + LOCK_CW'(1);
            end
         end
      end
      else
      begin
         s_nxt.lock     = 1'b0;
         s_nxt.lock_cnt = '0;
      end

      if (!s_r.boot)
      begin
         s_nxt.boot     = 1'b1;
         s_nxt.cur_src  = initial_source_config_in;
         s_nxt.next_src = initial_source_config_in;
      end
      else
      begin
         case (s_r.sw)
            osec_pkg::SW_IDLE:
            begin
               if (s_r.sw_go)
               begin
                  if (s_r.next_src == s_r.cur_src)
                  begin
                     s_nxt.sw_go = 1'b0;
                  end
                  else
                  begin
                     sw_start       = 1'b1;
                     s_nxt.lock     = 1'b0;
                     s_nxt.cf       = 1'b0;
                     s_nxt.lock_cnt = '0;
                     s_nxt.sw       = osec_pkg::SW_WAIT;
                  end
               end
            end
            osec_pkg::SW_WAIT:
            begin
               if (!uses_pll(s_r.next_src) || s_r.lock)
               begin
                  s_nxt.cur_src = s_r.next_src;
                  s_nxt.sw_go   = 1'b0;
                  s_nxt.sw      = osec_pkg::SW_IDLE;
               end
            end
            default:
            begin
               s_nxt.sw = osec_pkg::SW_IDLE;
            end
         endcase
      end

      // Register writes after both halves have arrived
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
      begin
         wr_fire      = 1'b1;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = osec_pkg::RESP_OKAY;
         s_nxt.unlock = 2'h0;
         if (s_r.awaddr == osec_pkg::ADDR_OSC_CTRL)
         begin
            if (s_r.unlock == 2'h2)
            begin
               wd = merge(ctrl_word(s_r), s_r.wdata, s_r.wstrb);
               s_nxt.next_src = wd[osec_pkg::NEXT_SRC_LSB +: 3];
               s_nxt.keep_on  = wd[osec_pkg::KEEP_ON_BIT];
               s_nxt.sw_go    = wd[osec_pkg::SWITCH_BIT];
            end
         end
         else if (s_r.awaddr == osec_pkg::ADDR_UNLOCK)
         begin
            if (s_r.wstrb[0] && (s_r.unlock == 2'h0)
                && (s_r.wdata[7:0] == osec_pkg::UNLOCK_KEY1))
            begin
               s_nxt.unlock = 2'h1;
            end
            else if (s_r.wstrb[0] && (s_r.unlock == 2'h1)
                     && (s_r.wdata[7:0] == osec_pkg::UNLOCK_KEY2))
            begin
               s_nxt.unlock = 2'h2;
            end
         end
         else if (s_r.awaddr == osec_pkg::ADDR_CLK_DIV)
         begin
            wd = merge({21'h0, s_r.div_sel, 8'h0}, s_r.wdata, s_r.wstrb);
            s_nxt.div_sel = wd[osec_pkg::DIV_LSB +: 3];
         end
         else if (s_r.awaddr == osec_pkg::ADDR_CONFIG)
         begin
            wd = merge({27'h0, s_r.cfg}, s_r.wdata, s_r.wstrb);
            s_nxt.cfg = wd[4:0];
         end
         else if (s_r.awaddr != osec_pkg::ADDR_STATUS)
         begin
            s_nxt.bresp = osec_pkg::RESP_SLVERR;
         end
      end

      // A clock failure overrides a clear in the same cycle
      if (clock_fail_in)
      begin
         s_nxt.cf      = 1'b1;
         s_nxt.cur_src = osec_pkg::SRC_FRC;
         s_nxt.sw_go   = 1'b0;
         s_nxt.sw      = osec_pkg::SW_IDLE;
      end

      // Read channel
      if (s_r.rvalid && s_axi_rready_in)
      begin
         s_nxt.rvalid  = 1'b0;
         s_nxt.arready = 1'b1;
      end
      if (s_r.arready && s_axi_arvalid_in)
      begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid  = 1'b1;
         s_nxt.rresp   = osec_pkg::RESP_OKAY;
         if (s_axi_araddr_in == osec_pkg::ADDR_OSC_CTRL)
         begin
            rd = ctrl_word(s_r);
         end
         else if (s_axi_araddr_in == osec_pkg::ADDR_CLK_DIV)
         begin
            rd[osec_pkg::DIV_LSB +: 3] = s_r.div_sel;
         end
         else if (s_axi_araddr_in == osec_pkg::ADDR_UNLOCK)
         begin
            rd[1:0] = s_r.unlock;
         end
         else if (s_axi_araddr_in == osec_pkg::ADDR_CONFIG)
         begin
            rd[4:0] = s_r.cfg;
         end
         else if (s_axi_araddr_in == osec_pkg::ADDR_STATUS)
         begin
            rd[4:0] = {s_r.sw == osec_pkg::SW_WAIT, s_r.en.pll, s_r.en.low_power_internal_rc,
                       s_r.en.fast_internal_rc, s_r.en.secondary_oscillator};
         end
         else
         begin
            s_nxt.rresp = osec_pkg::RESP_SLVERR;
         end
         s_nxt.rdata = rd;
      end

      // Registered oscillator enables
      s_nxt.en.secondary_oscillator_digital    = digital;
      s_nxt.en.secondary_oscillator_high_drive = !digital && (s_r.cfg[1:0] != 2'h0);
      s_nxt.en.secondary_oscillator = !digital && (s_r.keep_on
                       || (to_sec && !sleep_in)
                       || (AUTO_SECONDARY_OSCILLATOR && periph_needs_secondary_oscillator_in));
      s_nxt.en.fast_internal_rc  = !powerup_timer_expired_in || to_frc;
      if (powerup_timer_expired_in)
      begin
         s_nxt.en.low_power_internal_rc = s_r.cfg[osec_pkg::CFG_CLOCK_FAIL_MONITOR_BIT]
                         || s_r.cfg[osec_pkg::CFG_WDT_BIT] || to_low_power_internal_rc;
      end
      else
      begin
         s_nxt.en.low_power_internal_rc = s_r.cfg[osec_pkg::CFG_VREG_BIT];
      end
      s_nxt.en.pll          = uses_pll(target);
      s_nxt.en.frc_div_mode = s_r.cur_src == osec_pkg::SRC_FRC_DIV;
      s_nxt.en.frc_pll_mode = (s_r.cur_src == osec_pkg::SRC_FRC_PLL)
                              && (s_r.div_sel <= osec_pkg::DIV_BY_TWO);
      s_nxt.en.frc_pll_half = s_r.div_sel == osec_pkg::DIV_BY_TWO;
      s_nxt.en.usb_clk = HAS_96M_PLL && uses_pll(s_r.cur_src)
                         && ((s_r.cur_src != osec_pkg::SRC_FRC_PLL)
                             || (s_r.div_sel <= osec_pkg::DIV_BY_TWO));
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         s_r         <= '0;
         s_r.cfg     <= osec_pkg::CFG_RESET;
         s_r.awready <= 1'b1;
         s_r.wready  <= 1'b1;
         s_r.arready <= 1'b1;
         s_r.en.fast_internal_rc  <= 1'b1;
         s_r.en.low_power_internal_rc <= osec_pkg::CFG_RESET[osec_pkg::CFG_VREG_BIT];
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready_out        = s_r.awready;
   assign s_axi_wready_out         = s_r.wready;
   assign s_axi_bvalid_out         = s_r.bvalid;
   assign s_axi_bresp_out          = s_r.bresp;
   assign s_axi_arready_out        = s_r.arready;
   assign s_axi_rvalid_out         = s_r.rvalid;
   assign s_axi_rvalid_dummy_out   = s_r.rvalid;
   assign s_axi_rdata_out          = s_r.rdata;
   assign s_axi_rresp_out          = s_r.rresp;
   assign osc_en_out               = s_r.en;
   assign current_clock_source_out = s_r.cur_src;
   assign fast_rc_divider_select_out = s_r.div_sel;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   a_lock_stays_set: assert property (s_r.lock && s_r.en.pll && !sw_start
      && uses_pll(s_r.cur_src) && s_r.sw == osec_pkg::SW_IDLE |=> s_r.lock)
      else $error("settled flag dropped without a switch");
   a_lock_clear_nopll: assert property ((s_r.sw == osec_pkg::SW_IDLE)
      && !uses_pll(s_r.cur_src) |=> !s_r.lock)
      else $error("settled flag set on a non-PLL source");
   a_lock_after_count: assert property ($rose(s_r.lock) |->
      $past(s_r.lock_cnt) == LOCK_CW'(osec_pkg::LOCK_CYC - 1))
      else $error("settled flag rose before the lock interval");
   a_keep_on_secondary_oscillator: assert property (s_r.keep_on &&
      s_r.cfg[1:0] != osec_pkg::SMODE_DIGITAL |=> s_r.en.secondary_oscillator)
      else $error("secondary oscillator off with keep-on set");
   a_sleep_stops_secondary_oscillator: assert property (!s_r.keep_on && sleep_in && !periph_needs_secondary_oscillator_in
      && s_r.sw == osec_pkg::SW_IDLE |=> !s_r.en.secondary_oscillator)
      else $error("secondary oscillator ran in sleep");
   a_digital_no_drv: assert property (s_r.cfg[1:0] == osec_pkg::SMODE_DIGITAL
      |=> !s_r.en.secondary_oscillator && s_r.en.secondary_oscillator_digital)
      else $error("crystal driver on in digital mode");
   a_frc_before_powerup_timer: assert property (!powerup_timer_expired_in ##1 !powerup_timer_expired_in
      |-> s_r.en.fast_internal_rc)
      else $error("fast RC off before power-up timer expiry");
   a_low_power_internal_rc_shut_off: assert property (powerup_timer_expired_in && !s_r.cfg[osec_pkg::CFG_WDT_BIT]
      && !s_r.cfg[osec_pkg::CFG_CLOCK_FAIL_MONITOR_BIT] && s_r.cur_src != osec_pkg::SRC_LOW_POWER_INTERNAL_RC
      && s_r.sw == osec_pkg::SW_IDLE |=> !s_r.en.low_power_internal_rc)
      else $error("low-power RC left on without a user");
   a_unlock_guard: assert property (wr_fire && s_r.awaddr == osec_pkg::ADDR_OSC_CTRL
      && s_r.unlock != 2'h2 && !clock_fail_in |=> $stable(s_r.next_src)
      && $stable(s_r.keep_on))
      else $error("locked control register accepted a write");
   a_switch_clears: assert property (sw_start && !clock_fail_in
      |=> !s_r.cf && !s_r.lock && s_r.sw == osec_pkg::SW_WAIT)
      else $error("switch start kept settled or fail flag");
   a_div_mode_track: assert property ((s_r.cur_src == osec_pkg::SRC_FRC_DIV)
      |=> s_r.en.frc_div_mode)
      else $error("divided fast RC mode not reported");
endmodule : osec_ctrl

// >>> osec_pkg.sv
package osec_pkg;
   localparam logic [7:0] ADDR_OSC_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_CLK_DIV   = 8'h04;
   localparam logic [7:0] ADDR_UNLOCK    = 8'h08;
   localparam logic [7:0] ADDR_CONFIG    = 8'h0C;
   localparam logic [7:0] ADDR_STATUS    = 8'h10;
   localparam int CUR_SRC_LSB  = 12;
   localparam int NEXT_SRC_LSB = 8;
   localparam int LOCK_BIT     = 5;
   localparam int CF_BIT       = 3;
   localparam int KEEP_ON_BIT  = 1;
   localparam int SWITCH_BIT   = 0;
   localparam int DIV_LSB      = 8;
   localparam int CFG_WDT_BIT  = 2;
   localparam int CFG_CLOCK_FAIL_MONITOR_BIT = 3;
   localparam int CFG_VREG_BIT = 4;
   localparam logic [4:0] CFG_RESET = 5'h10;
   localparam logic [2:0] SRC_FRC      = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
   localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
   localparam logic [2:0] SRC_SEC      = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC     = 3'h4;
   localparam logic [2:0] SRC_FRC_DIV  = 3'h7;
   localparam logic [2:0] DIV_BY_TWO   = 3'h1;
   localparam logic [1:0] SMODE_HIGH   = 2'h1;
   localparam logic [1:0] SMODE_DIGITAL = 2'h2;
   localparam logic [7:0] UNLOCK_KEY1  = 8'h78;
   localparam logic [7:0] UNLOCK_KEY2  = 8'h9A;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int PLL_SETTLE_NS  = 2000;
   localparam int LOCK_CYC = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_CW  = $clog2(LOCK_CYC + 1);

   typedef enum logic [0:0] {SW_IDLE, SW_WAIT} osec_sw_type;

   typedef struct packed {
      logic secondary_oscillator;
      logic secondary_oscillator_high_drive;
      logic secondary_oscillator_digital;
      logic fast_internal_rc;
      logic low_power_internal_rc;
      logic pll;
      logic usb_clk;
      logic frc_div_mode;
      logic frc_pll_mode;
      logic frc_pll_half;
   } osec_en_type;

   typedef struct packed {
      logic [2:0]         cur_src;
      logic [2:0]         next_src;
      logic               lock;
      logic               cf;
      logic               keep_on;
      logic               sw_go;
      logic [2:0]         div_sel;
      logic [4:0]         cfg;
      logic [1:0]         unlock;
      osec_sw_type        sw;
      logic [LOCK_CW-1:0] lock_cnt;
      logic               boot;
      osec_en_type        en;
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               aw_got;
      logic               w_got;
      logic [7:0]         awaddr;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic               arready;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [31:0]        rdata;
   } osec_state_type;
endpackage : osec_pkg

// >>> osec_xtal_model.sv
module osec_xtal_model
(
   input  wire logic                  clk_sys_in,
   input  wire osec_pkg::osec_en_type en_in,
   output logic                       slow_clk_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] div_r = 4'h0;
   always @(posedge clk_sys_in)
   begin
      div_r <= div_r + 4'h1;
   end
   // Crystal swings only while driven; in digital mode the external source supplies it
   assign slow_clk_out = (en_in.secondary_oscillator || en_in.secondary_oscillator_digital) ? div_r[3] : 1'b0;
endmodule : osec_xtal_model

// >>> tb_oscillator_source_enable_control.sv
module tb_oscillator_source_enable_control;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [2:0] src;
      logic [4:0] cfg;
      logic       keep;
      logic       slp;
      logic       per;
      logic       powerup_timer;
      logic [7:0] exp;
   } osec_row_type;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
   logic rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awr, wr, bv, arr, rv, slow_clk;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic slp = 1'b0, powerup_timer = 1'b0, cfail = 1'b0, per = 1'b0;
   logic [2:0] init_src = 3'h0;
   logic [2:0] cur, dsel;
   osec_pkg::osec_en_type en;
   int err_count = 0, compares = 0, n;
   osec_row_type rows [12] = '{
      '{3'h0, 5'h10, 1'b0, 1'b0, 1'b0, 1'b0, 8'h18}, '{3'h7, 5'h10, 1'b0, 1'b0, 1'b0, 1'b1, 8'h12},
      '{3'h4, 5'h10, 1'b0, 1'b0, 1'b0, 1'b1, 8'h88}, '{3'h4, 5'h10, 1'b0, 1'b1, 1'b0, 1'b1, 8'h08},
      '{3'h4, 5'h10, 1'b1, 1'b1, 1'b0, 1'b1, 8'h88}, '{3'h0, 5'h10, 1'b1, 1'b0, 1'b0, 1'b1, 8'h90},
      '{3'h0, 5'h14, 1'b0, 1'b0, 1'b0, 1'b1, 8'h18}, '{3'h0, 5'h18, 1'b0, 1'b0, 1'b0, 1'b1, 8'h18},
      '{3'h0, 5'h10, 1'b0, 1'b0, 1'b1, 1'b1, 8'h90}, '{3'h0, 5'h11, 1'b1, 1'b0, 1'b0, 1'b1, 8'hD0},
      '{3'h0, 5'h12, 1'b1, 1'b0, 1'b0, 1'b1, 8'h30}, '{3'h1, 5'h10, 1'b0, 1'b0, 1'b0, 1'b1, 8'h15}};
   always #5 clk = ~clk;
   osec_ctrl osec_ctrl_i (.clk_sys_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rready), .s_axi_rvalid_dummy_out(), .sleep_in(slp),
      .powerup_timer_expired_in(powerup_timer),
      .clock_fail_in(cfail), .periph_needs_secondary_oscillator_in(per), .initial_source_config_in(init_src),
      .osc_en_out(en), .current_clock_source_out(cur), .fast_rc_divider_select_out(dsel));
   osec_xtal_model osec_xtal_model_i (.clk_sys_in(clk), .en_in(en), .slow_clk_out(slow_clk));
   task automatic stop_test();
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic hang(input string name);
      err_count++;
      $display("ERROR %s expected handshake seen none", name);
      stop_test();
   endtask : hang
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      logic done;
      done = 1'b0;
      r = 2'h3;
      @(posedge clk);
      awaddr <= a;
      wdata  <= d;
      awv    <= 1'b1;
      wv     <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100 && !done; k++)
      begin
         @(posedge clk);
         if (awv === 1'b1 && awr === 1'b1) awv <= 1'b0;
         if (wv === 1'b1 && wr === 1'b1) wv <= 1'b0;
         if (bv === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hang("write_response");
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      int k;
      logic done;
      done = 1'b0;
      d = 32'hFFFF_FFFF;
      @(posedge clk);
      araddr <= a;
      arv    <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100 && !done; k++)
      begin
         @(posedge clk);
         if (arv === 1'b1 && arr === 1'b1) arv <= 1'b0;
         if (rv === 1'b1)
         begin
            d = rdata;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hang("read_response");
   endtask : rd_reg
   task automatic ctrl_wr(input logic [31:0] d);
      wr_reg(8'h08, 32'h78, resp);
      wr_reg(8'h08, 32'h9A, resp);
      wr_reg(8'h00, d, resp);
   endtask : ctrl_wr
   task automatic do_reset(input logic [2:0] s);
      @(posedge clk);
      init_src <= s;
      rst      <= 1'b1;
      repeat (5) @(posedge clk);
      chk("reset_enables", 32'h3, {en.fast_internal_rc, en.low_power_internal_rc});
      chk("reset_source", 32'h0, cur);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : do_reset
   initial
   begin
      foreach (rows[i])
      begin
         slp  <= rows[i].slp;
         per  <= rows[i].per;
         powerup_timer <= rows[i].powerup_timer;
         do_reset(rows[i].src);
         wr_reg(8'h0C, {27'h0, rows[i].cfg}, resp);
         if (rows[i].keep) ctrl_wr({21'h0, rows[i].src, 8'h02});
         repeat (3) @(posedge clk);
         chk("enables", rows[i].exp, {en.secondary_oscillator, en.secondary_oscillator_high_drive, en.secondary_oscillator_digital, en.fast_internal_rc,
            en.low_power_internal_rc, en.pll, en.frc_div_mode, en.frc_pll_mode});
         chk("current_source", rows[i].src, cur);
         $display("Row %0d done", i);
      end
      slp  <= 1'b0;
      per  <= 1'b0;
      do_reset(3'h0);
      wr_reg(8'h00, 32'h2, resp);
      wr_reg(8'h08, 32'h78, resp);
      wr_reg(8'h0C, 32'h10, resp);
      wr_reg(8'h08, 32'h9A, resp);
      wr_reg(8'h00, 32'h2, resp);
      repeat (3) @(posedge clk);
      chk("keep_on_locked", 32'h0, en.secondary_oscillator);
      chk("slow_clock_idle", 32'h0, slow_clk);
      wr_reg(8'h20, 32'h1, resp);
      chk("unmapped_resp", osec_pkg::RESP_SLVERR, resp);
      wr_reg(8'h10, 32'hFF, resp);
      chk("status_resp", osec_pkg::RESP_OKAY, resp);
      $display("Unlock test done");
      ctrl_wr(32'h0000_0100);
      ctrl_wr(32'h0000_0101);
      for (n = 0; n < 400 && cur !== 3'h1; n++)
         @(posedge clk);
      chk("lock_wait", 32'h1, (n >= 150 && n <= 250));
      chk("pll_enable", 32'h1, en.pll);
      rd_reg(8'h00, rd);
      chk("ctrl_readback", 32'h1020, rd & 32'h7028);
      chk("usb_clock", 32'h1, en.usb_clk);
      wr_reg(8'h04, 32'h0000_0100, resp);
      repeat (2) @(posedge clk);
      chk("div_half", 32'h7, {en.frc_pll_mode, en.frc_pll_half, en.usb_clk});
      chk("div_select", 32'h1, dsel);
      wr_reg(8'h04, 32'h0000_0200, resp);
      repeat (2) @(posedge clk);
      chk("div_pll_off", 32'h0, {en.frc_pll_mode, en.frc_pll_half, en.usb_clk});
      chk("div_select", 32'h2, dsel);
      @(posedge clk);
      cfail <= 1'b1;
      @(posedge clk);
      cfail <= 1'b0;
      repeat (3) @(posedge clk);
      chk("fail_source", 32'h0, cur);
      rd_reg(8'h00, rd);
      chk("fail_readback", 32'h8, rd & 32'h7028);
      $display("Switch test done");
      stop_test();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      hang("run_length");
   end
endmodule : tb_oscillator_source_enable_control
